// ---- input_sleep_config_regs.sv ----
// Configuration registers for operating state, input rest states, bias rest states and pairing.
module input_sleep_config_regs
    import rest_cfg_pkg::*;
#(
    parameter int TICK_CYCLES = SLOT_TICK_CYCLES
) (
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [rest_cfg_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [rest_cfg_pkg::DATA_W-1:0] reg_wdata,
    output      logic [rest_cfg_pkg::DATA_W-1:0] reg_rdata,
    output      logic                         reg_rvalid,
    output      logic                         running,
    output      logic [3:0]                   active_slot,
    output      logic                         slot_start,
    output      rest_cfg_pkg::pair_switch_s   pair_a_switch,
    output      rest_cfg_pkg::pair_switch_s   pair_b_switch,
    output      rest_cfg_pkg::bias_drive_s    bias_one_drive,
    output      rest_cfg_pkg::bias_drive_s    bias_two_drive
);

    ////////////////////////////////////////////////////////////////////////////////
    // Stored fields.
    ////////////////////////////////////////////////////////////////////////////////

    logic       operating_state_select_reg;  // 0 standby, 1 running.
    logic [3:0] slot_count_select_reg;       // Number of slots minus one.
    logic [3:0] pair_b_rest_code_reg;        // First pair rest code.
    logic [3:0] pair_a_rest_code_reg;        // Second pair rest code.
    logic [1:0] bias_two_rest_code_reg;      // Second bias rest code.
    logic [1:0] bias_one_rest_code_reg;      // First bias rest code.
    logic       pair_b_differential_reg;     // First pair differential.
    logic       pair_a_differential_reg;     // Second pair differential.

    logic [3:0]   last_slot;     // Clamped last slot index.
    pair_switch_s pair_a_next;   // Decoded second pair switches.
    pair_switch_s pair_b_next;   // Decoded first pair switches.
    logic [DATA_W-1:0] rdata_next;  // Read value before the output flop.

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes.
    ////////////////////////////////////////////////////////////////////////////////

    // Operating state and slot count; reserved bits are not stored.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            operating_state_select_reg <= OP_STATE_RST;
            slot_count_select_reg      <= SLOT_COUNT_RST;
        end else if (reg_wr && reg_addr == OPMODE_ADDR) begin
            operating_state_select_reg <= reg_wdata[OP_STATE_BIT];
            slot_count_select_reg      <= reg_wdata[SLOT_COUNT_LSB +: 4];
        end
    end

    // Input pair rest codes; the middle byte is reserved and dropped.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pair_b_rest_code_reg <= REST_CODE_RST;
            pair_a_rest_code_reg <= REST_CODE_RST;
        end else if (reg_wr && reg_addr == INPUT_REST_ADDR) begin
            pair_b_rest_code_reg <= reg_wdata[PAIR_B_REST_LSB +: 4];
            pair_a_rest_code_reg <= reg_wdata[PAIR_A_REST_LSB +: 4];
        end
    end

    // Bias rest codes and pairing bits; reserved bits are dropped.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bias_two_rest_code_reg  <= BIAS_CODE_RST;
            bias_one_rest_code_reg  <= BIAS_CODE_RST;
            pair_b_differential_reg <= DIFF_RST;
            pair_a_differential_reg <= DIFF_RST;
        end else if (reg_wr && reg_addr == INPUT_PAIRING_ADDR) begin
            bias_two_rest_code_reg  <= reg_wdata[BIAS_TWO_LSB +: 2];
            bias_one_rest_code_reg  <= reg_wdata[BIAS_ONE_LSB +: 2];
            pair_b_differential_reg <= reg_wdata[PAIR_B_DIFF_BIT];
            pair_a_differential_reg <= reg_wdata[PAIR_A_DIFF_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register reads.
    ////////////////////////////////////////////////////////////////////////////////

    // Read mux; reserved bits and unmapped addresses read as zero.
    always_comb begin
        rdata_next = '0;
        unique case (reg_addr)
            OPMODE_ADDR: begin
                rdata_next[OP_STATE_BIT]        = operating_state_select_reg;
                rdata_next[SLOT_COUNT_LSB +: 4] = slot_count_select_reg;
            end
            INPUT_REST_ADDR: begin
                rdata_next[PAIR_B_REST_LSB +: 4] = pair_b_rest_code_reg;
                rdata_next[PAIR_A_REST_LSB +: 4] = pair_a_rest_code_reg;
            end
            INPUT_PAIRING_ADDR: begin
                rdata_next[BIAS_TWO_LSB +: 2]  = bias_two_rest_code_reg;
                rdata_next[BIAS_ONE_LSB +: 2]  = bias_one_rest_code_reg;
                rdata_next[PAIR_B_DIFF_BIT]    = pair_b_differential_reg;
                rdata_next[PAIR_A_DIFF_BIT]    = pair_a_differential_reg;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Read data is captured on the read strobe and held until the next read.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Rest state decode.
    ////////////////////////////////////////////////////////////////////////////////

    // First pair, built on the seventh and eighth inputs.
    pair_rest_decode u_pair_b_decode (
        .code         (pair_b_rest_code_reg),
        .differential (pair_b_differential_reg),
        .sw           (pair_b_next)
    );

    // Second pair, built on the first and second inputs.
    pair_rest_decode u_pair_a_decode (
        .code         (pair_a_rest_code_reg),
        .differential (pair_a_differential_reg),
        .sw           (pair_a_next)
    );

    // Rest switches act only in standby; while running the slot engine owns the inputs.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pair_a_switch <= '0;
            pair_b_switch <= '0;
        end else if (operating_state_select_reg) begin
            pair_a_switch <= '0;
            pair_b_switch <= '0;
        end else begin
            pair_a_switch <= pair_a_next;
            pair_b_switch <= pair_b_next;
        end
    end

    // Bias outputs follow their rest codes in standby and are released while running.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bias_one_drive <= '0;
            bias_two_drive <= '0;
        end else if (operating_state_select_reg) begin
            bias_one_drive <= '0;
            bias_two_drive <= '0;
        end else begin
            bias_one_drive <= bias_decode(bias_one_rest_code_reg);
            bias_two_drive <= bias_decode(bias_two_rest_code_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Operating state and slot sequencing.
    ////////////////////////////////////////////////////////////////////////////////

    // Slot count codes above eleven are clamped to all twelve slots.
    assign last_slot = (slot_count_select_reg > SLOT_LAST_CODE) ? SLOT_LAST_CODE
                                                                 : slot_count_select_reg;

    // Running flag mirrors the operating state bit.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            running <= 1'b0;
        end else begin
            running <= operating_state_select_reg;
        end
    end

    // Slots repeat continuously while running.
    slot_sequencer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_slot_sequencer (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .run         (operating_state_select_reg),
        .last_slot   (last_slot),
        .active_slot (active_slot),
        .slot_start  (slot_start)
    );

endmodule : input_sleep_config_regs

// ---- rest_cfg_pkg.sv ----
// Package with the register map, field layout, codes and types of the input rest configuration.
package rest_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register port geometry.
    ////////////////////////////////////////////////////////////////////////////////

    localparam int ADDR_W = 15;  // Width of the register address.
    localparam int DATA_W = 16;  // Width of every register.

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets.
    ////////////////////////////////////////////////////////////////////////////////

    localparam logic [ADDR_W-1:0] OPMODE_ADDR       = 15'h0010;  // Operating state and slot count.
    localparam logic [ADDR_W-1:0] INPUT_REST_ADDR   = 15'h0020;  // Input pair rest codes.
    localparam logic [ADDR_W-1:0] INPUT_PAIRING_ADDR = 15'h0021; // Pairing and bias rest codes.

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    ////////////////////////////////////////////////////////////////////////////////

    localparam int OP_STATE_BIT    = 0;   // Standby or running.
    localparam int SLOT_COUNT_LSB  = 8;   // Slot count field, four bits.
    localparam int PAIR_B_REST_LSB = 12;  // First pair rest code, four bits.
    localparam int PAIR_A_REST_LSB = 0;   // Second pair rest code, four bits.
    localparam int BIAS_TWO_LSB    = 6;   // Second bias rest code, two bits.
    localparam int BIAS_ONE_LSB    = 4;   // First bias rest code, two bits.
    localparam int PAIR_B_DIFF_BIT = 3;   // First pair differential bit.
    localparam int PAIR_A_DIFF_BIT = 0;   // Second pair differential bit.

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    ////////////////////////////////////////////////////////////////////////////////

    localparam logic       OP_STATE_RST   = 1'h0;  // Standby after reset.
    localparam logic [3:0] SLOT_COUNT_RST = 4'h0;  // Slot A only after reset.
    localparam logic [3:0] REST_CODE_RST  = 4'h0;  // Both inputs floating after reset.
    localparam logic [1:0] BIAS_CODE_RST  = 2'h0;  // Bias at supply after reset.
    localparam logic       DIFF_RST       = 1'h0;  // Single-ended after reset.

    ////////////////////////////////////////////////////////////////////////////////
    // Codes.
    ////////////////////////////////////////////////////////////////////////////////

    localparam logic [3:0] REST_FLOAT      = 4'h0;  // Both inputs float.
    localparam logic [3:0] REST_SHORT      = 4'h1;  // Floating short, differential only.
    localparam logic [3:0] REST_BOTH_ONE   = 4'h2;  // Both to first bias.
    localparam logic [3:0] REST_BOTH_TWO   = 4'h3;  // Both to second bias.
    localparam logic [3:0] REST_F1_SFLOAT  = 4'h4;  // First to bias one, second floats.
    localparam logic [3:0] REST_F1_S2      = 4'h5;  // First to bias one, second to bias two.
    localparam logic [3:0] REST_F2_SFLOAT  = 4'h6;  // First to bias two, second floats.
    localparam logic [3:0] REST_F2_S1      = 4'h7;  // First to bias two, second to bias one.
    localparam logic [3:0] REST_FFLOAT_S1  = 4'h8;  // First floats, second to bias one.
    localparam logic [3:0] REST_FFLOAT_S2  = 4'h9;  // First floats, second to bias two.

    localparam logic [1:0] BIAS_SUPPLY = 2'h0;  // Bias held at the analog supply rail.
    localparam logic [1:0] BIAS_GROUND = 2'h1;  // Bias held at ground.
    localparam logic [1:0] BIAS_FLOAT  = 2'h2;  // Bias left floating.

    localparam logic [3:0] SLOT_LAST_CODE = 4'hb;  // Highest slot count code, slots A to L.

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.
    ////////////////////////////////////////////////////////////////////////////////

    localparam int CLK_PERIOD_NS    = 8;     // Period of mclk.
    localparam int SLOT_PERIOD_NS   = 1000;  // Length of one time slot.
    localparam int SLOT_TICK_CYCLES = (SLOT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // Types.
    ////////////////////////////////////////////////////////////////////////////////

    // Switch controls of one input pair during rest.
    typedef struct packed {
        logic first_to_one;   // First input tied to bias output one.
        logic first_to_two;   // First input tied to bias output two.
        logic second_to_one;  // Second input tied to bias output one.
        logic second_to_two;  // Second input tied to bias output two.
        logic short_pair;     // Both inputs shorted together.
    } pair_switch_s;

    // Drive of one bias output during rest; neither bit set means floating.
    typedef struct packed {
        logic to_supply;  // Tied to the analog supply rail.
        logic to_ground;  // Tied to ground.
    } bias_drive_s;

    // Decode a bias rest code; unknown codes float.
    function automatic bias_drive_s bias_decode(input logic [1:0] code);
        bias_drive_s d;
        d.to_supply = (code == BIAS_SUPPLY);
        d.to_ground = (code == BIAS_GROUND);
        return d;
    endfunction : bias_decode

endpackage : rest_cfg_pkg

// ---- pair_rest_decode.sv ----
// Decoder from a four-bit rest code to the switch controls of one input pair.
module pair_rest_decode
    import rest_cfg_pkg::*;
(
    input  wire logic [3:0]                code,
    input  wire logic                      differential,
    output      rest_cfg_pkg::pair_switch_s sw
);

    ////////////////////////////////////////////////////////////////////////////////
    // Code table; codes above nine leave both inputs floating.
    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        sw = '0;
        unique case (code)
            REST_FLOAT: begin
                sw = '0;
            end
            REST_SHORT: begin
                sw.short_pair = differential;
            end
            REST_BOTH_ONE: begin
                sw.first_to_one  = 1'b1;
                sw.second_to_one = 1'b1;
                sw.short_pair    = differential;
            end
            REST_BOTH_TWO: begin
                sw.first_to_two  = 1'b1;
                sw.second_to_two = 1'b1;
                sw.short_pair    = differential;
            end
            REST_F1_SFLOAT: begin
                sw.first_to_one = 1'b1;
            end
            REST_F1_S2: begin
                sw.first_to_one  = 1'b1;
                sw.second_to_two = 1'b1;
            end
            REST_F2_SFLOAT: begin
                sw.first_to_two = 1'b1;
            end
            REST_F2_S1: begin
                sw.first_to_two  = 1'b1;
                sw.second_to_one = 1'b1;
            end
            REST_FFLOAT_S1: begin
                sw.second_to_one = 1'b1;
            end
            REST_FFLOAT_S2: begin
                sw.second_to_two = 1'b1;
            end
            default: begin
                sw = '0;
            end
        endcase
    end

endmodule : pair_rest_decode

// ---- slot_sequencer.sv ----
// Time slot sequencer that steps through the enabled slots while running.
module slot_sequencer
    import rest_cfg_pkg::*;
#(
    parameter int TICK_CYCLES = SLOT_TICK_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [3:0] last_slot,
    output      logic [3:0] active_slot,
    output      logic       slot_start
);

    localparam int TW = $clog2(TICK_CYCLES + 1);

    logic [TW-1:0] tick_reg;  // Divider that marks slot boundaries.
    logic          tick;      // One-cycle enable at each slot boundary.

    assign tick = (tick_reg == TW'(TICK_CYCLES - 1));

    // Divider runs only while running and restarts from zero on standby.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_reg <= '0;
        end else if (!run || tick) begin
            tick_reg <= '0;
        end else begin
            tick_reg <= tick_reg + TW'(1);
        end
    end

    // Slot index wraps after the last enabled slot, so the sequence repeats.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            active_slot <= 4'h0;
            slot_start  <= 1'b0;
        end else if (!run) begin
            active_slot <= 4'h0;
            slot_start  <= 1'b0;
        end else begin
            slot_start <= tick;
            if (tick) begin
                active_slot <= (active_slot >= last_slot) ? 4'h0 : active_slot + 4'h1;
            end
        end
    end

endmodule : slot_sequencer

// ---- rest_cfg_checker.sv ----
// Concurrent checks on the ports of the input rest configuration registers.
module rest_cfg_checker
    import rest_cfg_pkg::*;
#(
    parameter int TICK_CYCLES = SLOT_TICK_CYCLES
) (
    input wire logic                      mclk,
    input wire logic                      rst_n,
    input wire logic                      reg_wr,
    input wire logic                      reg_rd,
    input wire logic [rest_cfg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rest_cfg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [rest_cfg_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                      reg_rvalid,
    input wire logic                      running,
    input wire logic [3:0]                active_slot,
    input wire logic                      slot_start,
    input wire rest_cfg_pkg::pair_switch_s pair_a_switch,
    input wire rest_cfg_pkg::pair_switch_s pair_b_switch,
    input wire rest_cfg_pkg::bias_drive_s  bias_one_drive,
    input wire rest_cfg_pkg::bias_drive_s  bias_two_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////
    // All checks share the one clock and the reset.
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // A write of a pair code followed by two quiet standby cycles.
    sequence s_wr_b_two;
        reg_wr && reg_addr == INPUT_REST_ADDR && reg_wdata[15:12] == REST_BOTH_TWO;
    endsequence
    sequence s_wr_a_nine;
        reg_wr && reg_addr == INPUT_REST_ADDR && reg_wdata[3:0] == REST_FFLOAT_S2;
    endsequence
    sequence s_quiet;
        (!reg_wr && !running) [*2];
    endsequence
    property p_read_answer; reg_rd |=> reg_rvalid; endproperty
    property p_no_stray_valid; !reg_rd |=> !reg_rvalid; endproperty
    property p_rest_reserved;
        reg_rd && reg_addr == INPUT_REST_ADDR |=> reg_rdata[11:4] == 8'h00;
    endproperty
    property p_cfg_reserved;
        reg_rd && reg_addr == INPUT_PAIRING_ADDR |=> reg_rdata[15:8] == 8'h00
            && reg_rdata[2:1] == 2'h0;
    endproperty
    property p_run_releases;
        running && $past(running) |-> pair_a_switch == 5'h00 && pair_b_switch == 5'h00
            && bias_one_drive == 2'h0 && bias_two_drive == 2'h0;
    endproperty
    property p_standby_idle;
        !running && !$past(running) |-> !slot_start && active_slot == 4'h0;
    endproperty
    property p_pulse_single; slot_start |=> !slot_start [*2]; endproperty
    property p_bias_exclusive;
        !(bias_one_drive.to_supply && bias_one_drive.to_ground)
            && !(bias_two_drive.to_supply && bias_two_drive.to_ground);
    endproperty
    property p_decode_b_two;
        s_wr_b_two ##1 s_quiet |-> pair_b_switch.first_to_two && pair_b_switch.second_to_two
            && !pair_b_switch.first_to_one && !pair_b_switch.second_to_one;
    endproperty
    property p_decode_a_nine;
        s_wr_a_nine ##1 s_quiet |-> pair_a_switch == 5'h02;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    a_no_stray_valid: assert property (p_no_stray_valid) else $error("stray valid");
    a_rest_reserved: assert property (p_rest_reserved) else $error("rest bits");
    a_cfg_reserved: assert property (p_cfg_reserved) else $error("pairing bits");
    a_run_releases: assert property (p_run_releases) else $error("held while on");
    a_standby_idle: assert property (p_standby_idle) else $error("slots idle");
    a_pulse_single: assert property (p_pulse_single) else $error("slot pulse");
    a_bias_exclusive: assert property (p_bias_exclusive) else $error("bias clash");
    a_decode_b_two: assert property (p_decode_b_two) else $error("pair b code 3");
    a_decode_a_nine: assert property (p_decode_a_nine) else $error("pair a code 9");
endmodule : rest_cfg_checker

bind input_sleep_config_regs rest_cfg_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ---- input_sleep_config_regs_test.sv ----
// Self-checking testbench of the input rest configuration registers.
module input_sleep_config_regs_test import rest_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 4;  // Short slot length keeps the run brief.
    logic mclk, rst_n, reg_wr, reg_rd, reg_rvalid, running, slot_start;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [3:0]        active_slot;
    pair_switch_s      pair_a_switch, pair_b_switch;
    bias_drive_s       bias_one_drive, bias_two_drive;
    int                bad_count, checks;
    input_sleep_config_regs #(.TICK_CYCLES(TICK)) dut (.*);
    always #4 mclk = ~mclk;
    ////////////////////////////////////////
    // Compare one value and report a difference at once.
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Register write and read, strobes changed at the falling edge.
    task automatic wr(input logic [14:0] a, input logic [15:0] d);
        @(negedge mclk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge mclk) reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [14:0] a, input logic [15:0] exp);
        @(negedge mclk) {reg_rd, reg_addr} = {1'b1, a};
        @(negedge mclk) reg_rd = 1'b0;
        chk("rvalid", 16'h1, 16'(reg_rvalid));
        chk("rdata", exp, reg_rdata);
    endtask : rd
    // Expected switches, packed first_to_one down to short_pair.
    function automatic logic [4:0] exp_sw(input logic [3:0] c, input logic d);
        case (c)
            4'h1: return {4'b0000, d};
            4'h2: return {4'b1010, d};
            4'h3: return {4'b0101, d};
            4'h4: return 5'b10000;
            4'h5: return 5'b10010;
            4'h6: return 5'b01000;
            4'h7: return 5'b01100;
            4'h8: return 5'b00100;
            4'h9: return 5'b00010;
            default: return 5'b00000;
        endcase
    endfunction : exp_sw
    // Expected bias drive, to_supply then to_ground.
    function automatic logic [1:0] exp_bias(input logic [1:0] c);
        return (c == 2'h0) ? 2'b10 : (c == 2'h1) ? 2'b01 : 2'b00;
    endfunction : exp_bias
    ////////////////////////////////////////
    // Every field starts at zero, so the bias outputs sit at the supply.
    task automatic test_reset;
        rd(OPMODE_ADDR, 16'h0);
        rd(INPUT_REST_ADDR, 16'h0);
        rd(INPUT_PAIRING_ADDR, 16'h0);
        chk("bias1", 16'h2, 16'(bias_one_drive));
        chk("bias2", 16'h2, 16'(bias_two_drive));
        chk("swa", 16'h0, 16'(pair_a_switch));
    endtask : test_reset
    // All sixteen codes on both pairs, single-ended and differential.
    task automatic test_rest_codes;
        for (int d = 0; d < 2; d++) begin
            wr(INPUT_PAIRING_ADDR, {12'h0, d[0], 2'h0, d[0]});
            for (int c = 0; c < 16; c++) begin
                wr(INPUT_REST_ADDR, {c[3:0], 8'hff, c[3:0]});
                @(negedge mclk);
                chk("swb", 16'(exp_sw(c[3:0], d[0])), 16'(pair_b_switch));
                chk("swa", 16'(exp_sw(c[3:0], d[0])), 16'(pair_a_switch));
                rd(INPUT_REST_ADDR, {c[3:0], 8'h00, c[3:0]});
            end
        end
    endtask : test_rest_codes
    // Each bias code on both outputs, reserved bits dropped.
    task automatic test_bias;
        for (int i = 0; i < 4; i++) begin
            wr(INPUT_PAIRING_ADDR, {8'hff, 2'(3 - i), 2'(i), 4'hf});
            @(negedge mclk);
            chk("bias1", 16'(exp_bias(2'(i))), 16'(bias_one_drive));
            chk("bias2", 16'(exp_bias(2'(3 - i))), 16'(bias_two_drive));
            rd(INPUT_PAIRING_ADDR, {8'h00, 2'(3 - i), 2'(i), 4'h9});
        end
    endtask : test_bias
    // Running all twelve slots releases the rest switches until standby.
    task automatic test_running;
        int         pulses;
        logic [3:0] top;
        logic [3:0] prev;
        logic       wrapped;
        pulses = 0;
        top = 4'h0;
        wrapped = 1'b0;
        wr(INPUT_REST_ADDR, 16'h2002);
        wr(OPMODE_ADDR, 16'hfbff);
        @(negedge mclk);
        chk("running", 16'h1, 16'(running));
        chk("swb", 16'h0, 16'(pair_b_switch));
        chk("bias2", 16'h0, 16'(bias_two_drive));
        prev = active_slot;
        repeat (12 * TICK * 2 + 8) begin
            @(negedge mclk);
            pulses += int'(slot_start === 1'b1);
            if (active_slot > top) top = active_slot;
            if (prev == SLOT_LAST_CODE && active_slot == 4'h0) wrapped = 1'b1;
            prev = active_slot;
        end
        chk("top", 16'(SLOT_LAST_CODE), 16'(top));
        chk("wrap", 16'h1, 16'(wrapped));
        chk("pulses", 16'h1, 16'(pulses >= 24));
        rd(OPMODE_ADDR, 16'h0b01);
        wr(OPMODE_ADDR, 16'h0);
        @(negedge mclk);
        chk("running", 16'h0, 16'(running));
        chk("slot", 16'h0, 16'(active_slot));
        chk("swb", 16'h15, 16'(pair_b_switch));
    endtask : test_running
    // An unmapped address takes no write and reads zero.
    task automatic test_unmapped;
        wr(15'h0030, 16'hffff);
        rd(15'h0030, 16'h0);
        rd(INPUT_REST_ADDR, 16'h2002);
    endtask : test_unmapped
    ////////////////////////////////////////
    // Print the counts and the verdict, then stop.
    task automatic print_verdict;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    // Main sequence after a four-cycle reset.
    initial begin
        {mclk, rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        bad_count = 0;
        checks = 0;
        repeat (4) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        test_reset();
        test_rest_codes();
        test_bias();
        test_running();
        test_unmapped();
        print_verdict();
    end
    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end
endmodule : input_sleep_config_regs_test
